// File: logic/spc_pkg.sv
/*
 * spc_pkg: register map, field positions, reset values, modes and timing
 * constants of the serial port control block.
 * Assumes nothing of its surroundings.
 */
package spc_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] SPC_ADDR_RATE   = 8'h87;
  localparam logic [7:0] SPC_ADDR_CTRL   = 8'h98;
  localparam logic [7:0] SPC_ADDR_SBUF   = 8'h99;
  localparam logic [7:0] SPC_ADDR_ADDR   = 8'hA9;
  localparam logic [7:0] SPC_ADDR_BCAST  = 8'hB9;
  localparam logic [7:0] SPC_ADDR_DIV    = 8'hBA;
  localparam logic [7:0] SPC_ADDR_IRQST  = 8'hBB;
  localparam logic [7:0] SPC_ADDR_IRQMSK = 8'hBC;
  // reset values
  localparam logic [7:0] SPC_RATE_RST    = 8'h10;
  localparam logic [7:0] SPC_CTRL_RST    = 8'h00;
  localparam logic [7:0] SPC_DIV_RST     = 8'h04;
  // power_and_serial_rate_control fields
  localparam int SPC_RATE_DBL  = 7;
  localparam int SPC_RATE_VIEW = 6;
  // serial_port_control fields
  localparam int SPC_CTRL_MB0  = 7;
  localparam int SPC_CTRL_MB1  = 6;
  localparam int SPC_CTRL_MP   = 5;
  localparam int SPC_CTRL_REN  = 4;
  localparam int SPC_CTRL_TB8  = 3;
  localparam int SPC_CTRL_RB8  = 2;
  localparam int SPC_CTRL_TI   = 1;
  localparam int SPC_CTRL_RI   = 0;
  // interrupt status bits
  localparam int SPC_IRQ_TX = 0;
  localparam int SPC_IRQ_RX = 1;
  localparam int SPC_IRQ_FE = 2;
  // oscillator clocks per machine cycle: 12-clock mode
  localparam int SPC_CLK_PER_CYC = 12;
  // fixed-rate divisor of mode 2: 64 clocks per bit, 32 when doubled
  localparam int SPC_MODE2_DIV   = 64;
  localparam int SPC_SAMPLES     = 16;
  localparam logic [3:0] SPC_MID = 4'h7;
  localparam logic [3:0] SPC_BITS8 = 4'h8;
  localparam logic [3:0] SPC_BITS9 = 4'h9;
  typedef enum logic [1:0] {
    SPC_M_SHIFT = 2'b00,
    SPC_M_UART8 = 2'b01,
    SPC_M_FIX9  = 2'b10,
    SPC_M_VAR9  = 2'b11
  } spc_mode_t;
  typedef enum logic [1:0] {
    SPC_IDLE  = 2'b00,
    SPC_START = 2'b01,
    SPC_DATA  = 2'b11,
    SPC_STOP  = 2'b10
  } spc_state_t;
endpackage : spc_pkg

// File: logic/spc_top.sv
/*
 * spc_top: control and status logic of the serial port: mode select,
 * baud timing, receiver with framing check and address recognition,
 * flags and interrupt. Transmit shifter is spc_tx.
 * Assumes a plain register port on SYS_CLK and an asynchronous line.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module spc_top import spc_pkg::*; #(
  parameter int CLK_PER_CYC = SPC_CLK_PER_CYC
) (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // serial line
  input  wire logic       RXD_IN,
  output logic            TXD,
  output logic            SHIFT_CLK,
  // interrupt
  output logic            IRQ
);
  localparam int DIVW = 16;
  logic rst_s1_ff, rst_n;
  logic rxd_s1_ff, rxd_s2_ff;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= RXD_IN;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic s);
    hit = s && (a == b);
  endfunction : hit

  typedef struct packed {
    logic [7:0]  rate;
    logic [7:0]  ctrl;
    logic        fe;
    logic [7:0]  rbuf;
    logic [7:0]  own_addr;
    logic [7:0]  bcast;
    logic [DIVW-1:0] div;
    logic [2:0]  irq_st;
    logic [2:0]  irq_msk;
    logic [DIVW-1:0] pre;
    logic [3:0]  tx_sub;
    spc_state_t  rst_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_cnt;
    logic [8:0]  rx_sh;
    logic        rx_prev;
    logic [7:0]  rdata;
    logic        irq;
  } spc_state_all_t;
  spc_state_all_t s_ff, nxt_s;

  logic [1:0] mode;
  logic       tx_load, tx_busy, tx_done, txd_w, sclk_w;
  logic       samp_tick, bit_tick, tx_tick;
  logic [DIVW-1:0] period;
  logic       rx_set, fe_set, sh_tick;

  assign mode = {s_ff.ctrl[SPC_CTRL_MB0], s_ff.ctrl[SPC_CTRL_MB1]};
  assign tx_load = WR && (ADDR == SPC_ADDR_SBUF) && !tx_busy;

  // oversampling period per bit/16; mode 0 runs one bit per machine cycle
  always_comb begin
    case (mode)
      SPC_M_SHIFT: period = DIVW'(CLK_PER_CYC);
      SPC_M_FIX9:  period = s_ff.rate[SPC_RATE_DBL] ?
                            DIVW'(SPC_MODE2_DIV / (2 * SPC_SAMPLES)) : DIVW'(SPC_MODE2_DIV / SPC_SAMPLES);
      default:     period = s_ff.rate[SPC_RATE_DBL] ?
                            {1'b0, s_ff.div[DIVW-1:1]} : s_ff.div;
    endcase
  end
  assign samp_tick = (s_ff.pre == '0);
  assign tx_tick   = (mode == SPC_M_SHIFT) ? samp_tick : (samp_tick && s_ff.tx_sub == '0);
  assign sh_tick   = samp_tick;

  spc_tx u_tx (
    .clk       (SYS_CLK),
    .rst_n     (rst_n),
    .mode      (mode),
    .tb8       (s_ff.ctrl[SPC_CTRL_TB8]),
    .load      (tx_load),
    .data      (WDATA),
    .tick      (tx_tick),
    .txd       (txd_w),
    .shift_clk (sclk_w),
    .busy      (tx_busy),
    .done      (tx_done)
  );

  always_comb begin
    logic [7:0] rv;
    logic       stop_ok, accept, nine;
    logic       rb8_new, rb8_upd;
    rv      = '0;
    rb8_new = 1'b0;
    rb8_upd = 1'b0;
    stop_ok = 1'b0;
    accept  = 1'b0;
    nine    = 1'b0;
    nxt_s   = s_ff;
    rx_set  = 1'b0;
    fe_set  = 1'b0;
    bit_tick = 1'b0;
    nxt_s.rx_prev = rxd_s2_ff;
    // prescaler and transmit bit divider
    nxt_s.pre = samp_tick ? ((period == '0) ? '0 : period - DIVW'(1)) : s_ff.pre - DIVW'(1);
    if (samp_tick) begin
      nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
    end
    // receiver
    case (s_ff.rst_st)
      SPC_IDLE: begin
        if (s_ff.ctrl[SPC_CTRL_REN]) begin
          if (mode == SPC_M_SHIFT) begin
            if (!s_ff.ctrl[SPC_CTRL_RI]) begin
              nxt_s.rst_st = SPC_DATA;
              nxt_s.rx_cnt = '0;
            end
          end else if (s_ff.rx_prev && !rxd_s2_ff) begin
            nxt_s.rst_st = SPC_START;
            nxt_s.rx_sub = '0;
          end
        end
      end
      SPC_START: if (sh_tick) begin
        nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
        if (s_ff.rx_sub == SPC_MID) begin
          nxt_s.rst_st = rxd_s2_ff ? SPC_IDLE : SPC_DATA;
          nxt_s.rx_sub = '0;
          nxt_s.rx_cnt = '0;
        end
      end
      SPC_DATA: if (sh_tick) begin
        nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
        bit_tick = (mode == SPC_M_SHIFT) || (s_ff.rx_sub == 4'(SPC_SAMPLES - 1));
        if (bit_tick) begin
          nxt_s.rx_sh  = {rxd_s2_ff, s_ff.rx_sh[8:1]};
          nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
          if (mode == SPC_M_SHIFT && s_ff.rx_cnt == SPC_BITS8 - 4'h1) begin
            nxt_s.rst_st = SPC_IDLE;
            nxt_s.rbuf   = {rxd_s2_ff, s_ff.rx_sh[8:2]};
            rx_set       = 1'b1;
          end else if (s_ff.rx_cnt == (mode[1] ? SPC_BITS9 : SPC_BITS8) - 4'h1) begin
            nxt_s.rst_st = SPC_STOP;
          end
        end
      end
      SPC_STOP: if (sh_tick) begin
        nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
        if (s_ff.rx_sub == 4'(SPC_SAMPLES - 1)) begin
          // halfway through the stop bit
          nxt_s.rst_st = SPC_IDLE;
          stop_ok = rxd_s2_ff;
          fe_set  = !stop_ok;
          nine    = mode[1] ? s_ff.rx_sh[8] : stop_ok;
          if (mode[1]) begin
            accept = !s_ff.ctrl[SPC_CTRL_MP] || (nine &&
                     (hit(s_ff.rx_sh[7:0], s_ff.own_addr, 1'b1) || hit(s_ff.rx_sh[7:0], s_ff.bcast, 1'b1)));
          end else begin
            accept = !s_ff.ctrl[SPC_CTRL_MP] || stop_ok;
          end
          if (accept && !s_ff.ctrl[SPC_CTRL_RI]) begin
            nxt_s.rbuf = mode[1] ? s_ff.rx_sh[7:0] : s_ff.rx_sh[8:1];
            // applied after the register writes so a same-cycle write cannot drop it
            rb8_new = mode[1] ? nine : stop_ok;
            rb8_upd = mode[1] || !s_ff.ctrl[SPC_CTRL_MP];
            rx_set  = 1'b1;
          end
        end
      end
      default: nxt_s.rst_st = SPC_IDLE;
    endcase
    // register writes
    if (WR) begin
      case (ADDR)
        SPC_ADDR_RATE: nxt_s.rate = {WDATA[7:6], s_ff.rate[5:0]};
        SPC_ADDR_CTRL: begin
          nxt_s.ctrl = WDATA;
          if (s_ff.rate[SPC_RATE_VIEW]) begin
            nxt_s.ctrl[SPC_CTRL_MB0] = s_ff.ctrl[SPC_CTRL_MB0];
            nxt_s.fe = WDATA[SPC_CTRL_MB0];
          end
        end
        SPC_ADDR_ADDR:   nxt_s.own_addr = WDATA;
        SPC_ADDR_BCAST:  nxt_s.bcast = WDATA;
        SPC_ADDR_DIV:    nxt_s.div = {{(DIVW-8){1'b0}}, WDATA};
        SPC_ADDR_IRQST:  nxt_s.irq_st = s_ff.irq_st & ~WDATA[2:0];
        SPC_ADDR_IRQMSK: nxt_s.irq_msk = WDATA[2:0];
        default: ;
      endcase
    end
    // hardware sets win over software clears
    if (tx_done) begin
      nxt_s.ctrl[SPC_CTRL_TI] = 1'b1;
      nxt_s.irq_st[SPC_IRQ_TX] = 1'b1;
    end
    if (rx_set) begin
      nxt_s.ctrl[SPC_CTRL_RI] = 1'b1;
      if (rb8_upd) begin
        nxt_s.ctrl[SPC_CTRL_RB8] = rb8_new;
      end
      nxt_s.irq_st[SPC_IRQ_RX] = 1'b1;
    end
    if (fe_set) begin
      nxt_s.fe = 1'b1;
      nxt_s.irq_st[SPC_IRQ_FE] = 1'b1;
    end
    // reads
    if (RD) begin
      case (ADDR)
        SPC_ADDR_RATE:   rv = s_ff.rate;
        SPC_ADDR_CTRL: begin
          rv = s_ff.ctrl;
          rv[SPC_CTRL_MB0] = s_ff.rate[SPC_RATE_VIEW] ? s_ff.fe : s_ff.ctrl[SPC_CTRL_MB0];
        end
        SPC_ADDR_SBUF:   rv = s_ff.rbuf;
        SPC_ADDR_ADDR:   rv = s_ff.own_addr;
        SPC_ADDR_BCAST:  rv = s_ff.bcast;
        SPC_ADDR_DIV:    rv = s_ff.div[7:0];
        SPC_ADDR_IRQST:  rv = {5'h00, s_ff.irq_st};
        SPC_ADDR_IRQMSK: rv = {5'h00, s_ff.irq_msk};
        default:         rv = 8'h00;
      endcase
    end
    nxt_s.rdata = rv;
    nxt_s.irq   = |(nxt_s.irq_st & nxt_s.irq_msk);
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{rate: SPC_RATE_RST, ctrl: SPC_CTRL_RST, fe: 1'b0, rbuf: '0, own_addr: '0, bcast: '0,
                div: DIVW'(SPC_DIV_RST), irq_st: '0, irq_msk: '0, pre: '0, tx_sub: '0,
                rst_st: SPC_IDLE, rx_sub: '0, rx_cnt: '0, rx_sh: '0, rx_prev: 1'b1, rdata: '0, irq: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign RDATA     = s_ff.rdata;
  assign IRQ       = s_ff.irq;
  assign TXD       = txd_w;
  assign SHIFT_CLK = sclk_w;

  AST_RI_ON_RX: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    rx_set |=> s_ff.ctrl[SPC_CTRL_RI]) else $error("receive flag not set");
  AST_TI_ON_TX: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    tx_done |=> s_ff.ctrl[SPC_CTRL_TI]) else $error("transmit flag not set");
  AST_FE_STICKY: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    s_ff.fe && !(WR && ADDR == SPC_ADDR_CTRL) |=> s_ff.fe) else $error("framing flag lost");
  AST_FE_SET: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    fe_set |=> s_ff.fe) else $error("framing flag not set");
  AST_NO_RX_DISABLED: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    s_ff.rst_st == SPC_IDLE && !s_ff.ctrl[SPC_CTRL_REN] |=> s_ff.rst_st == SPC_IDLE)
    else $error("receiver started while disabled");
  AST_VIEW_READ: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    RD && ADDR == SPC_ADDR_CTRL && s_ff.rate[SPC_RATE_VIEW] && !fe_set && !WR
    |=> RDATA[SPC_CTRL_MB0] == $past(s_ff.fe)) else $error("bit 7 view wrong");
  AST_MP_MODE1: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    rx_set && mode == SPC_M_UART8 && s_ff.ctrl[SPC_CTRL_MP] |-> !fe_set)
    else $error("receive flag despite bad stop");
  AST_MP_ADDR: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    rx_set && mode[1] && s_ff.ctrl[SPC_CTRL_MP] |=> s_ff.ctrl[SPC_CTRL_RB8])
    else $error("address frame without ninth bit");
  AST_DBL_PERIOD: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    mode == SPC_M_FIX9 && s_ff.rate[SPC_RATE_DBL] |-> period == DIVW'(SPC_MODE2_DIV / (2 * SPC_SAMPLES)))
    else $error("double rate not applied");
  AST_IRQ_LEVEL: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    IRQ == |(s_ff.irq_st & s_ff.irq_msk)) else $error("interrupt level wrong");
  CV_RX: cover property (@(posedge SYS_CLK) disable iff (!rst_n) rx_set);
  CV_TX: cover property (@(posedge SYS_CLK) disable iff (!rst_n) tx_done);
  CV_FE: cover property (@(posedge SYS_CLK) disable iff (!rst_n) fe_set);
  CV_IRQ: cover property (@(posedge SYS_CLK) disable iff (!rst_n) IRQ);
endmodule : spc_top

// File: logic/spc_tx.sv
/*
 * spc_tx: transmit shifter of the serial port.
 * Assumes a one-cycle tick per bit time and a one-cycle load strobe
 * from the control logic, both on the same clock.
 */
`timescale 1ns/1ps
module spc_tx import spc_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic [1:0] mode,
  input  wire logic       tb8,
  input  wire logic       load,
  input  wire logic [7:0] data,
  input  wire logic       tick,
  // line and events
  output logic            txd,
  output logic            shift_clk,
  output logic            busy,
  output logic            done
);
  typedef struct packed {
    spc_state_t st;
    logic [8:0] sh;
    logic [3:0] cnt;
    logic       txd;
    logic       sclk;
    logic       done;
  } spc_tx_t;
  spc_tx_t cur_ff, nxt_cur;

  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'b0;
    case (cur_ff.st)
      SPC_IDLE: begin
        nxt_cur.txd  = 1'b1;
        nxt_cur.sclk = 1'b1;
        if (load) begin
          nxt_cur.sh  = {tb8, data};
          nxt_cur.cnt = '0;
          nxt_cur.st  = (mode == SPC_M_SHIFT) ? SPC_DATA : SPC_START;
        end
      end
      SPC_START: if (tick) begin
        nxt_cur.txd = 1'b0;
        nxt_cur.st  = SPC_DATA;
      end
      SPC_DATA: if (tick) begin
        nxt_cur.txd  = cur_ff.sh[0];
        nxt_cur.sh   = {1'b1, cur_ff.sh[8:1]};
        nxt_cur.cnt  = cur_ff.cnt + 4'h1;
        nxt_cur.sclk = (mode == SPC_M_SHIFT) ? 1'b0 : 1'b1;
        // ninth bit only in modes 2 and 3
        if (cur_ff.cnt == ((mode[1]) ? SPC_BITS9 : SPC_BITS8)) begin
          nxt_cur.txd = 1'b1;
          nxt_cur.sclk = 1'b1;
          if (mode == SPC_M_SHIFT) begin
            nxt_cur.st   = SPC_IDLE;
            nxt_cur.done = 1'b1;
          end else begin
            nxt_cur.st   = SPC_STOP;
            nxt_cur.done = 1'b1;
          end
        end
      end else if (mode == SPC_M_SHIFT) begin
        nxt_cur.sclk = 1'b1;
      end
      SPC_STOP: if (tick) begin
        nxt_cur.st = SPC_IDLE;
      end
      default: nxt_cur.st = SPC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{st: SPC_IDLE, sh: '0, cnt: '0, txd: 1'b1, sclk: 1'b1, done: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign txd       = cur_ff.txd;
  assign shift_clk = cur_ff.sclk;
  assign busy      = (cur_ff.st != SPC_IDLE);
  assign done      = cur_ff.done;

  AST_TX_STOP_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    cur_ff.st == SPC_STOP |-> txd) else $error("stop bit not high");
  AST_TX_DONE_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
    done |=> !done) else $error("transmit done longer than one cycle");
endmodule : spc_tx

// File: sim/spc_remote_node.sv
/*
 * spc_remote_node: remote serial node at the line side of spc_top.
 * Decodes async frames and mode-0 shifted bytes from the block, and
 * sends async frames into the block with a good or broken stop bit.
 * Assumes the bench clock and a bit length given in clock cycles.
 */
`timescale 1ns/1ps
module spc_remote_node (
  // clock
  input  wire logic       clk,
  // line from the block, bit length and frame size from the bench
  input  wire logic       txd,
  input  wire logic       shift_clk,
  input  var  int         bit_cycles,
  input  var  int         frame_bits,
  // line into the block and decoded frames
  output logic            rxd,
  output logic      [9:0] got,
  output logic            got_valid
);
  logic       sc_prev = 1'b1;
  logic       txd_low = 1'b1;
  logic [7:0] sh      = 8'h00;
  int         n_sh    = 0;
  logic       rxd_ff  = 1'b1;
  logic [9:0] got_a   = 10'h000;
  logic [9:0] got_s   = 10'h000;
  logic       val_a   = 1'b0;
  logic       val_s   = 1'b0;

  // one driver per output: async and shift decoders merged here
  assign rxd       = rxd_ff;
  assign got       = val_a ? got_a : got_s;
  assign got_valid = val_a || val_s;

  // async decode: start, data lsb first, optional ninth, stop in bit 9
  always begin : async_rx
    logic [9:0] f;
    logic       start_ok;
    @(negedge txd);
    if (bit_cycles > 0) begin
      f = 10'h000;
      repeat (bit_cycles / 2) @(posedge clk);
      start_ok = !txd;
      for (int i = 0; i < frame_bits; i++) begin
        repeat (bit_cycles) @(posedge clk);
        f[i] = txd;
      end
      repeat (bit_cycles) @(posedge clk);
      f[9] = txd;
      if (!start_ok)
        f = 10'h3FF;
      got_a <= f;
      val_a <= 1'b1;
      @(posedge clk);
      val_a <= 1'b0;
    end
  end

  // mode-0 shift register: data taken while the shift clock is low
  always @(posedge clk) begin : shift_rx
    sc_prev <= shift_clk;
    if (!shift_clk)
      txd_low <= txd;
    if (bit_cycles == 0) begin
      val_s <= shift_clk && !sc_prev && n_sh == 7;
      if (shift_clk && !sc_prev) begin
        sh   <= {txd_low, sh[7:1]};
        n_sh <= (n_sh == 7) ? 0 : n_sh + 1;
        got_s <= {2'b00, txd_low, sh[7:1]};
      end
    end
  end

  // frame into the block; line held high afterwards
  task automatic send_frame(input logic [8:0] val, input int nbits, input logic stop_bit, input int bitc);
    @(posedge clk);
    rxd_ff <= 1'b0;
    repeat (bitc) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rxd_ff <= val[i];
      repeat (bitc) @(posedge clk);
    end
    rxd_ff <= stop_bit;
    repeat (bitc) @(posedge clk);
    rxd_ff <= 1'b1;
    repeat (bitc) @(posedge clk);
  endtask : send_frame
endmodule : spc_remote_node

// File: sim/test_serial_port_control.sv
/*
 * test_serial_port_control: self-checking bench of spc_top.
 * Drives the register port, checks read data and decoded frames through
 * queues of expected values. Assumes spc_remote_node on the line side.
 */
`timescale 1ns/1ps
module test_serial_port_control import spc_pkg::*; ;
  logic       sys_clk   = 1'b0;
  logic       rst_b     = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic       rd_d      = 1'b0;
  logic [7:0] rdata;
  logic       rxd;
  logic       txd;
  logic       shift_clk;
  logic       irq;
  logic [9:0] got;
  logic       got_valid;
  int         bitc      = 32;
  int         nbits     = 8;
  int         err_total = 0;
  int         samples_checked = 0;
  int         cycles    = 0;
  logic [7:0] reg_q[$];
  logic [9:0] frm_q[$];

  always #4 sys_clk = ~sys_clk;

  spc_top spc_top_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RXD_IN(rxd), .TXD(txd), .SHIFT_CLK(shift_clk), .IRQ(irq));
  spc_remote_node spc_remote_node_inst (.clk(sys_clk), .txd(txd), .shift_clk(shift_clk), .bit_cycles(bitc),
    .frame_bits(nbits), .rxd(rxd), .got(got), .got_valid(got_valid));

  task automatic chk_reg(input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected RDATA expected %h seen %h", exp, seen);
    end
  endtask : chk_reg

  task automatic chk_frame(input logic [9:0] exp, input logic [9:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected frame expected %h seen %h", exp, seen);
    end
  endtask : chk_frame

  task automatic chk_irq(input logic exp);
    samples_checked++;
    if (irq !== exp) begin
      err_total++;
      $display("unexpected IRQ expected %b seen %b", exp, irq);
    end
  endtask : chk_irq

  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    reg_q.push_back(exp);
    @(posedge sys_clk);
    rd   <= 1'b0;
  endtask : rd_reg

  task automatic send(input logic [8:0] v, input int n, input logic stop_bit);
    spc_remote_node_inst.send_frame(v, n, stop_bit, bitc);
  endtask : send

  task automatic wait_line;
    for (int i = 0; i < 4000 && frm_q.size() > 0; i++) @(posedge sys_clk);
    // mode 0 sets the transmit flag one machine cycle after the last bit
    repeat (bitc + 16) @(posedge sys_clk);
  endtask : wait_line

  // result watcher and hang guard
  always @(posedge sys_clk) begin
    rd_d <= rd;
    cycles++;
    if (rd_d)
      chk_reg(reg_q.size() > 0 ? reg_q.pop_front() : 8'hxx, rdata);
    if (got_valid)
      chk_frame(frm_q.size() > 0 ? frm_q.pop_front() : 10'hxxx, got);
    if (cycles == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin : main
    logic [7:0] b;
    logic [8:0] fv;
    logic [1:0] md;
    logic       t8;
    void'($urandom(6));
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_reg(SPC_ADDR_RATE, SPC_RATE_RST);
    rd_reg(SPC_ADDR_CTRL, SPC_CTRL_RST);
    rd_reg(SPC_ADDR_DIV, SPC_DIV_RST);
    rd_reg(8'h55, 8'h00);
    wr_reg(SPC_ADDR_DIV, 8'h02);
    wr_reg(SPC_ADDR_IRQMSK, 8'h01);
    // transmit in modes 1, 3, 2 doubled, 3 doubled, 2 plain
    for (int k = 0; k < 5; k++) begin
      md    = (k == 0) ? 2'b01 : (k == 2 || k == 4) ? 2'b10 : 2'b11;
      t8    = (k == 1 || k == 4) ? 1'b1 : (k == 3) ? 1'($urandom_range(1)) : 1'b0;
      bitc  = (k == 3) ? 16 : (k == 4) ? 64 : 32;
      nbits = (k == 0) ? 8 : 9;
      wr_reg(SPC_ADDR_RATE, (k == 2 || k == 3) ? 8'h80 : 8'h00);
      wr_reg(SPC_ADDR_CTRL, {md, 2'b00, t8, 3'b000});
      b = 8'($urandom_range(255));
      frm_q.push_back({1'b1, (k == 0) ? 1'b0 : t8, b});
      wr_reg(SPC_ADDR_SBUF, b);
      wait_line();
      rd_reg(SPC_ADDR_CTRL, {md, 2'b00, t8, 3'b010});
      chk_irq(1'b1);
      wr_reg(SPC_ADDR_IRQST, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk_irq(1'b0);
    end
    // mode 0 shift out, multiprocessor bit kept clear
    wr_reg(SPC_ADDR_RATE, 8'h00);
    bitc = 0;
    wr_reg(SPC_ADDR_CTRL, 8'h00);
    wr_reg(SPC_ADDR_IRQMSK, 8'h00);
    b = 8'($urandom_range(255));
    frm_q.push_back({2'b00, b});
    wr_reg(SPC_ADDR_SBUF, b);
    wait_line();
    rd_reg(SPC_ADDR_CTRL, 8'h02);
    rd_reg(SPC_ADDR_IRQST, 8'h01);
    chk_irq(1'b0);
    wr_reg(SPC_ADDR_IRQST, 8'h07);
    wr_reg(SPC_ADDR_IRQMSK, 8'h02);
    // mode 1 receive, disabled then enabled
    bitc = 32;
    wr_reg(SPC_ADDR_CTRL, 8'h40);
    send({1'b0, b}, 8, 1'b1);
    rd_reg(SPC_ADDR_CTRL, 8'h40);
    chk_irq(1'b0);
    wr_reg(SPC_ADDR_CTRL, 8'h50);
    b = 8'($urandom_range(255));
    send({1'b0, b}, 8, 1'b1);
    rd_reg(SPC_ADDR_CTRL, 8'h55);
    rd_reg(SPC_ADDR_SBUF, b);
    chk_irq(1'b1);
    wr_reg(SPC_ADDR_IRQST, 8'h02);
    // broken stop bit: framing flag, view select, sticky until written
    wr_reg(SPC_ADDR_CTRL, 8'h50);
    send({1'b0, b}, 8, 1'b0);
    rd_reg(SPC_ADDR_CTRL, 8'h51);
    wr_reg(SPC_ADDR_RATE, 8'h40);
    rd_reg(SPC_ADDR_RATE, 8'h50);
    rd_reg(SPC_ADDR_CTRL, 8'hD1);
    send({1'b0, b}, 8, 1'b1);
    rd_reg(SPC_ADDR_CTRL, 8'hD1);
    rd_reg(SPC_ADDR_IRQST, 8'h06);
    wr_reg(SPC_ADDR_CTRL, 8'h50);
    rd_reg(SPC_ADDR_CTRL, 8'h50);
    wr_reg(SPC_ADDR_RATE, 8'h00);
    wr_reg(SPC_ADDR_IRQST, 8'h07);
    // mode 1 with multiprocessor bit: flag needs a valid stop
    wr_reg(SPC_ADDR_CTRL, 8'h70);
    send({1'b0, b}, 8, 1'b0);
    rd_reg(SPC_ADDR_CTRL, 8'h70);
    send({1'b0, b}, 8, 1'b1);
    rd_reg(SPC_ADDR_CTRL, 8'h71);
    wr_reg(SPC_ADDR_IRQST, 8'h07);
    // mode 3 address filter: data, wrong, own, broadcast
    wr_reg(SPC_ADDR_ADDR, 8'h5A);
    wr_reg(SPC_ADDR_BCAST, 8'hC3);
    for (int k = 0; k < 4; k++) begin
      fv = (k == 0) ? 9'h05A : (k == 1) ? 9'h133 : (k == 2) ? 9'h15A : 9'h1C3;
      wr_reg(SPC_ADDR_CTRL, 8'hF0);
      send(fv, 9, 1'b1);
      rd_reg(SPC_ADDR_IRQST, (k >= 2) ? 8'h02 : 8'h00);
      if (k >= 2)
        rd_reg(SPC_ADDR_CTRL, 8'hF5);
      wr_reg(SPC_ADDR_IRQST, 8'h07);
    end
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule : test_serial_port_control
